// >>> dcm_burst_addr.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcm_defs.svh"
module dcm_burst_addr (
  input wire logic [2:0] i_start,
  input wire logic [2:0] i_idx,
  input wire logic [2:0] i_bl,
  input wire logic i_interleaved,
  output logic [2:0] o_low
);
  logic [2:0] m;
  logic [2:0] sum;
  always_comb
  begin
    // R25 length code decode
    case (i_bl)
      `DCM_BL4: m = 3'h3;
      `DCM_BL8: m = 3'h7;
      default: m = 3'h1;
    endcase
    sum = i_start + i_idx;
    // R1 block wraps
    // R4 xor ordering
    if (i_interleaved)
      o_low = ((i_start ^ i_idx) & m) | (i_start & ~m);
    else
      // R2 R3 modulo step
      o_low = (sum & m) | (i_start & ~m);
  end
endmodule : dcm_burst_addr
`default_nettype wire

// >>> dcm_cmd_mode.sv
// What this block does
// R1 - burst of two: A1 upward pick block, A0 first word, wrap inside
// R2 - burst of four: A2 upward pick block, A0-A1 start, step modulo four
// R3 - burst of eight: A3 upward pick block, A0-A2 start, step modulo eight
// R4 - interleaved: nth word is start low bits xor n
// R5 - read registered at edge n gives first data at edge n plus latency
// R6 - controller picks a latency allowed for its grade and clock rate
// R7 - mode load with operating bits zero selects normal operation
// R8 - mode load with loop reset bit alone starts loop reset, bit self-clears
// R9 - controller should follow loop reset with a normal mode load
// R10 - controller writes no other operating-mode codes
// R11 - bank bits 01 write extended register, 00 base, others reserved
// R12 - after enabling the loop controller loads base register with loop reset
// R13 - mode loads only with banks idle, then wait before next command
// R14 - controller waits 200 clock-enable-high cycles after loop enable before reads
// R15 - leaving self refresh re-enables the loop automatically
// R16 - commands decode from strobes with clock enable high, except self refresh
// R17 - deselect and no-operation behave identically
// R18 - read or write: bank bits, column, precharge flag asks auto precharge
// R19 - controller uses burst terminate only on reads without auto precharge
// R20 - precharge flag low closes named bank, high closes all banks
// R21 - refresh encoding: auto refresh if clock enable high, else self refresh
// R22 - write mask low writes the word, high suppresses it
// R23 - base fields: A0-A2 length, A3 type, A4-A6 latency, upper operating mode
// R24 - read latency is two or two and a half clocks; this block runs two and a half as three clocks
// R25 - length codes 001 two, 010 four, 011 eight, others reserved
`timescale 1ns/1ns
`default_nettype none
`include "dcm_defs.svh"
module dcm_cmd_mode #(
  parameter int COL_W = `DCM_COL_W,
  parameter int ADDR_W = `DCM_ADDR_W,
  parameter int DW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_bank_select_bit_zero,
  input wire logic i_bank_select_bit_one,
  input wire logic [1:0] i_write_word_mask,
  input wire logic [2*DW-1:0] i_dq,
  input wire logic i_dqs,
  input wire logic [2*DW-1:0] i_arr_rdata,
  output logic [2*DW-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_dqs,
  output logic o_dqs_oe,
  output logic o_arr_rd,
  output logic [1:0] o_arr_we,
  output logic o_arr_ref,
  output logic [1:0] o_arr_bank,
  output logic [ADDR_W-1:0] o_arr_row,
  output logic [2*COL_W-1:0] o_arr_col,
  output logic [2*DW-1:0] o_arr_wdata,
  output logic [2:0] o_burst_len,
  output logic o_burst_interleaved,
  output logic [2:0] o_read_latency_setting,
  output logic o_dll_enabled,
  output logic o_drive_reduced,
  output logic o_dll_ready,
  output logic o_self_refresh,
  output logic [3:0] o_banks_open
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] lrst_q;
  logic link_rst;
  // reset release retimed into the link domain
  always_ff @(posedge i_link_clk or posedge i_rst)
  begin
    if (i_rst)
      lrst_q <= 2'h3;
    else
      lrst_q <= {lrst_q[0], 1'b0};
  end
  assign link_rst = lrst_q[1];

  ////////////////////////////////////////////////////////////////////////////
  dcm_pkg::dcm_cmd_t cmd;
  logic [1:0] bank;
  logic [6:0] opm;
  assign bank = {i_bank_select_bit_one, i_bank_select_bit_zero};
  assign opm = i_addr[`DCM_OPM_LSB +: 7];
  // R16 strobe decode
  // R17 deselect equals nop
  always_comb
  begin
    cmd = dcm_pkg::CMD_NOP;
    if (!i_cs_n)
    begin
      case ({i_ras_n, i_cas_n, i_we_n})
        3'h3: cmd = dcm_pkg::CMD_ACT;
        3'h5: cmd = dcm_pkg::CMD_RD;
        3'h4: cmd = dcm_pkg::CMD_WR;
        3'h6: cmd = dcm_pkg::CMD_BST;
        3'h2: cmd = dcm_pkg::CMD_PRE;
        3'h1: cmd = dcm_pkg::CMD_REF;
        3'h0: cmd = dcm_pkg::CMD_MRS;
        default: cmd = dcm_pkg::CMD_NOP;
      endcase
    end
    // R21 low clock enable turns refresh into self refresh
    if (!i_cke)
      cmd = (cmd == dcm_pkg::CMD_REF) ? dcm_pkg::CMD_SREF : dcm_pkg::CMD_NOP;
  end

  ////////////////////////////////////////////////////////////////////////////
  dcm_pkg::dcm_state_t st_q;
  logic [2:0] bl_q;
  logic bt_q;
  logic [2:0] cl_q;
  logic dll_en_q;
  logic drive_q;
  logic [7:0] lock_q;
  logic dll_ready;
  logic loop_start;
  logic mrs_base;
  logic mrs_ext;
  assign mrs_base = (cmd == dcm_pkg::CMD_MRS) && (bank == 2'h0);
  assign mrs_ext = (cmd == dcm_pkg::CMD_MRS) && (bank == 2'h1);
  // R8 loop reset code, bit never stored
  assign loop_start = mrs_base && (opm == 7'h02);
  // R23 base fields
  // R7 normal mode stores settings
  // reserved operating codes leave the settings untouched
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      bl_q <= `DCM_BL_RST;
      bt_q <= `DCM_BT_RST;
      cl_q <= `DCM_CL_RST;
    end
    else if (mrs_base && (opm == 7'h00 || loop_start))
    begin
      bl_q <= i_addr[`DCM_BL_LSB +: 3];
      bt_q <= i_addr[`DCM_BT_BIT];
      cl_q <= i_addr[`DCM_CL_LSB +: 3];
    end
  end
  // R11 extended register select
  // R15 self refresh exit enables loop
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      dll_en_q <= `DCM_DLL_EN_RST;
      drive_q <= `DCM_DRIVE_RST;
    end
    else if (mrs_ext)
    begin
      dll_en_q <= ~i_addr[`DCM_EXT_DLL_OFF_BIT];
      drive_q <= i_addr[`DCM_EXT_DRIVE_BIT];
    end
    else if (st_q == dcm_pkg::ST_SREF && i_cke)
      dll_en_q <= 1'b1;
  end
  // lock wait restarts on any enable or loop reset; counts only with cke high
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
      lock_q <= 8'h00;
    else if (!dll_en_q || loop_start || (mrs_ext && !i_addr[`DCM_EXT_DLL_OFF_BIT])
             || (st_q == dcm_pkg::ST_SREF && i_cke))
      lock_q <= 8'h00;
    else if (i_cke && lock_q != `DCM_DLL_LOCK_CYC)
      lock_q <= lock_q + 8'h01;
  end
  assign dll_ready = dll_en_q && (lock_q == `DCM_DLL_LOCK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] cnt_q;
  logic wait_q;
  logic [COL_W-1:0] col_q;
  logic [1:0] bank_q;
  logic ap_q;
  logic [1:0] last_idx;
  logic rd_issue;
  logic wr_issue;
  logic done;
  assign last_idx = (bl_q == `DCM_BL8) ? 2'h3 : (bl_q == `DCM_BL4) ? 2'h1 : 2'h0;
  assign rd_issue = (st_q == dcm_pkg::ST_RD) && !wait_q && cmd != dcm_pkg::CMD_BST;
  assign wr_issue = (st_q == dcm_pkg::ST_WR) && i_dqs;
  assign done = (rd_issue || wr_issue) && cnt_q == last_idx;
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      st_q <= dcm_pkg::ST_IDLE;
      cnt_q <= 2'h0;
      wait_q <= 1'b0;
      col_q <= '0;
      bank_q <= 2'h0;
      ap_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        dcm_pkg::ST_IDLE:
        begin
          cnt_q <= 2'h0;
          // R18 latch bank, column, auto precharge
          if (cmd == dcm_pkg::CMD_RD || cmd == dcm_pkg::CMD_WR)
          begin
            st_q <= (cmd == dcm_pkg::CMD_RD) ? dcm_pkg::ST_RD : dcm_pkg::ST_WR;
            // R24 half clock extra waits one cycle
            wait_q <= (cl_q == `DCM_CL25);
            col_q <= i_addr[COL_W-1:0];
            bank_q <= bank;
            ap_q <= i_addr[`DCM_PRECHARGE_FLAG_BIT];
          end
          else if (cmd == dcm_pkg::CMD_SREF)
            st_q <= dcm_pkg::ST_SREF;
        end
        dcm_pkg::ST_RD:
        begin
          if (cmd == dcm_pkg::CMD_BST)
            st_q <= dcm_pkg::ST_IDLE;
          else if (wait_q)
            wait_q <= 1'b0;
          else if (done)
            st_q <= dcm_pkg::ST_IDLE;
          else
            cnt_q <= cnt_q + 2'h1;
        end
        dcm_pkg::ST_WR:
        begin
          if (done)
            st_q <= dcm_pkg::ST_IDLE;
          else if (wr_issue)
            cnt_q <= cnt_q + 2'h1;
        end
        dcm_pkg::ST_SREF:
        begin
          if (i_cke)
            st_q <= dcm_pkg::ST_IDLE;
        end
        default: st_q <= dcm_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] open_q;
  logic [ADDR_W-1:0] row_q [4];
  logic [ADDR_W-1:0] ref_row_q;
  // R20 single or all banks
  // auto precharge closes after the last pair; a later activate still wins
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
      open_q <= 4'h0;
    else
    begin
      if (done && ap_q)
        open_q[bank_q] <= 1'b0;
      if (cmd == dcm_pkg::CMD_PRE)
      begin
        if (i_addr[`DCM_PRECHARGE_FLAG_BIT])
          open_q <= 4'h0;
        else
          open_q[bank] <= 1'b0;
      end
      if (cmd == dcm_pkg::CMD_ACT)
        open_q[bank] <= 1'b1;
    end
  end
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      for (int b = 0; b < 4; b++)
        row_q[b] <= '0;
    end
    else if (cmd == dcm_pkg::CMD_ACT)
      row_q[bank] <= i_addr;
  end
  // R21 internal refresh row counter
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
      ref_row_q <= '0;
    else if (cmd == dcm_pkg::CMD_REF)
      ref_row_q <= ref_row_q + ADDR_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2*COL_W-1:0] lane_col;
  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    logic [2:0] low;
    dcm_burst_addr u_addr (
      .i_start(col_q[2:0]),
      .i_idx({cnt_q, 1'(g)}),
      .i_bl(bl_q),
      .i_interleaved(bt_q),
      .o_low(low)
    );
    assign lane_col[g*COL_W +: COL_W] = {col_q[COL_W-1:3], low};
  end
  // array side runs one cycle ahead of the pins
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      o_arr_rd <= 1'b0;
      o_arr_we <= 2'h0;
      o_arr_ref <= 1'b0;
      o_arr_bank <= 2'h0;
      o_arr_row <= '0;
      o_arr_col <= '0;
      o_arr_wdata <= '0;
    end
    else
    begin
      o_arr_rd <= rd_issue;
      // R22 mask low writes
      o_arr_we <= wr_issue ? ~i_write_word_mask : 2'h0;
      o_arr_ref <= (cmd == dcm_pkg::CMD_REF);
      o_arr_bank <= bank_q;
      o_arr_row <= (cmd == dcm_pkg::CMD_REF) ? ref_row_q : row_q[bank_q];
      o_arr_col <= lane_col;
      o_arr_wdata <= i_dq;
    end
  end
  // R5 data lands latency edges after the read
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe <= 1'b0;
    end
    else
    begin
      o_dq <= o_arr_rd ? i_arr_rdata : '0;
      o_dq_oe <= o_arr_rd;
      o_dqs <= o_arr_rd;
      o_dqs_oe <= o_arr_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [`DCM_STAT_W-1:0] live;
  logic [`DCM_STAT_W-1:0] snap_q;
  logic [`DCM_STAT_W-1:0] core_q;
  logic req_q;
  logic ack_q;
  logic req_s;
  logic ack_s;
  assign live = {open_q, st_q == dcm_pkg::ST_SREF, dll_ready, drive_q, dll_en_q,
                 cl_q, bt_q, bl_q};
  // snapshot held until the core acknowledges, so words never tear
  always_ff @(posedge i_link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      snap_q <= '0;
      req_q <= 1'b0;
    end
    else if (req_q == ack_s && live != snap_q)
    begin
      snap_q <= live;
      req_q <= ~req_q;
    end
  end
  dcm_sync #(.W(1)) u_ack_sync (
    .i_clk(i_link_clk),
    .i_rst(link_rst),
    .i_d(ack_q),
    .o_q(ack_s)
  );
  dcm_sync #(.W(1)) u_req_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(req_q),
    .o_q(req_s)
  );
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      core_q <= '0;
      ack_q <= 1'b0;
    end
    else if (req_s != ack_q)
    begin
      core_q <= snap_q;
      ack_q <= req_s;
    end
  end
  assign {o_banks_open, o_self_refresh, o_dll_ready, o_drive_reduced, o_dll_enabled,
          o_read_latency_setting, o_burst_interleaved, o_burst_len} = core_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_rd_cl2;
    cmd == dcm_pkg::CMD_RD && st_q == dcm_pkg::ST_IDLE && cl_q == `DCM_CL2;
  endsequence
  sequence s_rd_cl25;
    cmd == dcm_pkg::CMD_RD && st_q == dcm_pkg::ST_IDLE && cl_q == `DCM_CL25;
  endsequence
  AST_RD_LAT2: assert property (@(posedge i_link_clk) disable iff (link_rst) // R5
    s_rd_cl2 |=> !o_dq_oe[*2] ##1 o_dq_oe)
    else $error("read data not at latency two");
  AST_RD_LAT25: assert property (@(posedge i_link_clk) disable iff (link_rst) // R24
    s_rd_cl25 |=> !o_dq_oe[*3] ##1 o_dq_oe)
    else $error("read data not at latency two and a half");
  AST_BLOCK: assert property (@(posedge i_link_clk) disable iff (link_rst) // R1
    o_arr_rd |-> o_arr_col[COL_W-1:3] == o_arr_col[2*COL_W-1:COL_W+3]
      && (bl_q != `DCM_BL2 || o_arr_col[2:1] == o_arr_col[COL_W+2:COL_W+1]))
    else $error("burst left its block");
  AST_SEQ: assert property (@(posedge i_link_clk) disable iff (link_rst) // R3
    (o_arr_rd && !bt_q && bl_q == `DCM_BL8)
      |-> o_arr_col[COL_W+2:COL_W] == o_arr_col[2:0] + 3'h1)
    else $error("sequential step wrong");
  AST_INTLV: assert property (@(posedge i_link_clk) disable iff (link_rst) // R4
    (o_arr_rd && bt_q) |-> o_arr_col[COL_W] == ~o_arr_col[0])
    else $error("interleaved order wrong");
  AST_LOOP_RST: assert property (@(posedge i_link_clk) disable iff (link_rst) // R8
    (loop_start && dll_en_q) |=> lock_q == 8'h00 ##1 lock_q <= 8'h01)
    else $error("loop reset did not restart lock wait");
  AST_EXT: assert property (@(posedge i_link_clk) disable iff (link_rst) // R11
    mrs_ext |=> dll_en_q == !$past(i_addr[`DCM_EXT_DLL_OFF_BIT])
      && drive_q == $past(i_addr[`DCM_EXT_DRIVE_BIT]))
    else $error("extended register not written");
  AST_SREF_EXIT: assert property (@(posedge i_link_clk) disable iff (link_rst) // R15
    (st_q == dcm_pkg::ST_SREF && i_cke) |=> dll_en_q && st_q == dcm_pkg::ST_IDLE)
    else $error("self refresh exit left loop off");
  AST_PRE_ALL: assert property (@(posedge i_link_clk) disable iff (link_rst) // R20
    (cmd == dcm_pkg::CMD_PRE && i_addr[`DCM_PRECHARGE_FLAG_BIT]) |=> open_q == 4'h0)
    else $error("precharge all left a bank open");
  AST_MASK: assert property (@(posedge i_link_clk) disable iff (link_rst) // R22
    $past(wr_issue) |-> o_arr_we == ~$past(i_write_word_mask))
    else $error("write mask not honoured");
  AST_NOP: assert property (@(posedge i_link_clk) disable iff (link_rst) // R17
    (i_cs_n && i_cke && st_q == dcm_pkg::ST_IDLE) |=> st_q == dcm_pkg::ST_IDLE
      && open_q == $past(open_q) && !o_arr_ref)
    else $error("deselect changed state");
endmodule : dcm_cmd_mode
`default_nettype wire

// >>> dcm_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dcm_ctrl_model (
  input wire logic i_link_clk,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [13:0] o_addr,
  output logic o_bank_select_bit_zero,
  output logic o_bank_select_bit_one,
  output logic [1:0] o_write_word_mask,
  output logic [15:0] o_dq,
  output logic o_dqs
);
  initial
  begin
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_addr = 14'h0000;
    {o_bank_select_bit_one, o_bank_select_bit_zero} = 2'h0;
    o_write_word_mask = 2'h0;
    o_dq = 16'h0000;
    o_dqs = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one command per edge
  // released data lines flip on every issued command so a stale sample never looks valid
  task automatic issue(input logic k, input logic [3:0] c, input logic [13:0] a,
                       input logic [1:0] ba);
    @(posedge i_link_clk);
    #2;
    o_cke = k;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_addr = a;
    {o_bank_select_bit_one, o_bank_select_bit_zero} = ba;
    o_dqs = 1'b0;
    o_dq = ~o_dq;
    o_write_word_mask = ~o_write_word_mask;
  endtask : issue
  //////////////////////////////////////////////////////////////////////////////
  // beat under deselect
  task automatic beat(input logic [1:0] m, input logic [15:0] d);
    @(posedge i_link_clk);
    #2;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_dqs = 1'b1;
    o_dq = d;
    o_write_word_mask = m;
  endtask : beat
endmodule : dcm_ctrl_model
`default_nettype wire

// >>> dcm_defs.svh
`ifndef DCM_DEFS_SVH
`define DCM_DEFS_SVH
`define DCM_ADDR_W 14
`define DCM_COL_W 10
`define DCM_BL_LSB 0
`define DCM_BT_BIT 3
`define DCM_CL_LSB 4
`define DCM_OPM_LSB 7
`define DCM_LOOP_RESET_BIT 8
`define DCM_PRECHARGE_FLAG_BIT 10
`define DCM_EXT_DLL_OFF_BIT 0
`define DCM_EXT_DRIVE_BIT 1
`define DCM_BL2 3'h1
`define DCM_BL4 3'h2
`define DCM_BL8 3'h3
`define DCM_CL2 3'h2
`define DCM_CL25 3'h6
`define DCM_BL_RST 3'h1
`define DCM_BT_RST 1'h0
`define DCM_CL_RST 3'h6
`define DCM_DLL_EN_RST 1'h0
`define DCM_DRIVE_RST 1'h0
`define DCM_DLL_LOCK_CYC 8'hC8
`define DCM_STAT_W 15
`endif

// >>> dcm_pkg.sv
`default_nettype none
package dcm_pkg;
  typedef enum logic [8:0]
  {
    CMD_NOP = 9'h001,
    CMD_ACT = 9'h002,
    CMD_RD = 9'h004,
    CMD_WR = 9'h008,
    CMD_BST = 9'h010,
    CMD_PRE = 9'h020,
    CMD_REF = 9'h040,
    CMD_SREF = 9'h080,
    CMD_MRS = 9'h100
  } dcm_cmd_t;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_RD = 4'h2,
    ST_WR = 4'h4,
    ST_SREF = 4'h8
  } dcm_state_t;
endpackage : dcm_pkg
`default_nettype wire

// >>> dcm_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dcm_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= i_d;
      s2_q <= s1_q;
    end
  end
  assign o_q = s2_q;
endmodule : dcm_sync
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcm_defs.svh"
`define CHECK_EQ(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module tb;
  localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4, RD = 4'h5, BST = 4'h6, NOP = 4'h7;
  logic i_clk = 1'b0;
  logic link_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, ba0, ba1, dqs, dq_oe, dqs_out, dqs_oe, arr_rd;
  logic arr_ref, bt, dll_en, drv, dll_rdy, sref;
  logic [13:0] addr, arr_row;
  logic [1:0] dm, arr_we, arr_bank;
  logic [15:0] dq_in, dq_out, arr_rdata, arr_wdata;
  logic [19:0] arr_col;
  logic [2:0] bl, rl;
  logic [3:0] banks;
  logic [37:0] wq[$];
  int err_count = 0;
  int n_checks = 0;
  int ref_cnt = 0;
  int rd_cnt = 0;
  logic [13:0] ref_row;
  //////////////////////////////////////////////////////////////////////////////
  always #50 i_clk = ~i_clk;
  initial #7 forever #15 link_clk = ~link_clk;
  function automatic logic [15:0] rdat(input logic [9:0] c1, input logic [9:0] c0);
    return {c1[7:0] ^ 8'hA5, c0[7:0]};
  endfunction : rdat
  // array stand-in answers combinationally from the column pair
  assign arr_rdata = rdat(arr_col[19:10], arr_col[9:0]);
  dcm_ctrl_model i_ctrl (.i_link_clk(link_clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_bank_select_bit_zero(ba0),
    .o_bank_select_bit_one(ba1), .o_write_word_mask(dm), .o_dq(dq_in), .o_dqs(dqs));
  dcm_cmd_mode i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr),
    .i_bank_select_bit_zero(ba0), .i_bank_select_bit_one(ba1), .i_write_word_mask(dm),
    .i_dq(dq_in), .i_dqs(dqs), .i_arr_rdata(arr_rdata), .o_dq(dq_out), .o_dq_oe(dq_oe),
    .o_dqs(dqs_out), .o_dqs_oe(dqs_oe), .o_arr_rd(arr_rd), .o_arr_we(arr_we),
    .o_arr_ref(arr_ref), .o_arr_bank(arr_bank), .o_arr_row(arr_row), .o_arr_col(arr_col),
    .o_arr_wdata(arr_wdata), .o_burst_len(bl), .o_burst_interleaved(bt),
    .o_read_latency_setting(rl), .o_dll_enabled(dll_en), .o_drive_reduced(drv),
    .o_dll_ready(dll_rdy), .o_self_refresh(sref), .o_banks_open(banks));
  always @(posedge link_clk)
  begin
    #1;
    if (arr_we !== 2'b00)
      wq.push_back({arr_we, arr_wdata, arr_col});
    if (arr_ref === 1'b1)
    begin
      ref_cnt++;
      ref_row = arr_row;
    end
    if (arr_rd === 1'b1)
      rd_cnt++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // status crosses into the slow domain, so give it a dozen core cycles
  task automatic wait_core;
    repeat (12) @(posedge i_clk);
    #2;
  endtask : wait_core
  task automatic nop(input logic k);
    i_ctrl.issue(k, NOP, 14'h0000, 2'h0);
  endtask : nop
  task automatic rd_burst(input logic [2:0] blc, input logic il, input logic [2:0] st,
                          input logic [2:0] clc);
    int len;
    int p;
    int q;
    logic [9:0] c[8];
    len = 1 << blc;
    p = 0;
    q = 0;
    for (int n = 0; n < len; n++)
      c[n] = 10'h2A8 | 10'(il ? (st ^ n) : ((st + n) % len));
    // load only with banks idle, allowed latency
    i_ctrl.issue(1'b1, MRS, {7'h00, clc, il, blc}, 2'h0);
    i_ctrl.issue(1'b1, ACT, 14'h0123, 2'h2);
    i_ctrl.issue(1'b1, RD, {4'h0, c[0]}, 2'h2);
    nop(1'b1);
    for (int k = 1; k < 13; k++)
    begin
      @(posedge link_clk);
      #1;
      if (arr_rd === 1'b1 && p < len / 2)
      begin
        `CHECK_EQ(arr_col, {c[2*p+1], c[2*p]});
        `CHECK_EQ({arr_bank, arr_row}, {2'h2, 14'h0123});
        p++;
      end
      if (dq_oe === 1'b1)
      begin
        if (q == 0)
          `CHECK_EQ(k, (clc == `DCM_CL25) ? 3 : 2);
        `CHECK_EQ(dq_out, rdat(c[2*q+1], c[2*q]));
        `CHECK_EQ({dqs_out, dqs_oe}, 2'h3);
        q++;
      end
    end
    `CHECK_EQ(q, len / 2);
    i_ctrl.issue(1'b1, PRE, 14'h0400, 2'h0);
  endtask : rd_burst
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    err_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(posedge i_clk);
    #2;
    i_rst = 1'b0;
    wait_core;
    `CHECK_EQ(bl, `DCM_BL_RST);
    `CHECK_EQ(rl, `DCM_CL_RST);
    `CHECK_EQ(dll_en, `DCM_DLL_EN_RST);
    // enable, loop reset, then normal mode
    i_ctrl.issue(1'b1, MRS, 14'h0002, 2'h1);
    i_ctrl.issue(1'b1, MRS, 14'h0122, 2'h0);
    i_ctrl.issue(1'b1, MRS, 14'h0022, 2'h0);
    i_ctrl.issue(1'b1, MRS, 14'h0033, 2'h3);
    nop(1'b1);
    repeat (140) @(posedge link_clk);
    `CHECK_EQ(dll_rdy, 1'b0);
    wait_core;
    repeat (100) @(posedge link_clk);
    `CHECK_EQ(dll_rdy, 1'b1);
    `CHECK_EQ(bl, `DCM_BL4);
    `CHECK_EQ(rl, `DCM_CL2);
    `CHECK_EQ(bt, 1'b0);
    `CHECK_EQ(drv, 1'b1);
    `CHECK_EQ(dll_en, 1'b1);
    for (int b = 1; b < 4; b++)
      for (int t = 0; t < 2; t++)
        for (int s = 0; s < (1 << b); s++)
          rd_burst(3'(b), t[0], 3'(s), s[0] ? `DCM_CL25 : `DCM_CL2);
    // terminate a plain read after its first pair
    i_ctrl.issue(1'b1, MRS, 14'h0023, 2'h0);
    i_ctrl.issue(1'b1, ACT, 14'h0077, 2'h0);
    rd_cnt = 0;
    i_ctrl.issue(1'b1, RD, 14'h0000, 2'h0);
    nop(1'b1);
    i_ctrl.issue(1'b1, BST, 14'h0000, 2'h0);
    nop(1'b1);
    repeat (6) @(posedge link_clk);
    `CHECK_EQ(rd_cnt, 1);
    i_ctrl.issue(1'b1, PRE, 14'h0400, 2'h0);
    i_ctrl.issue(1'b1, MRS, 14'h0022, 2'h0);
    i_ctrl.issue(1'b1, ACT, 14'h0055, 2'h1);
    nop(1'b1);
    wait_core;
    `CHECK_EQ(banks, 4'h2);
    wq.delete();
    i_ctrl.issue(1'b1, WR, 14'h0440, 2'h1);
    i_ctrl.beat(2'b10, 16'h1234);
    i_ctrl.beat(2'b01, 16'h5678);
    nop(1'b1);
    wait_core;
    `CHECK_EQ(wq.size(), 2);
    `CHECK_EQ(wq[0], {2'b01, 16'h1234, 10'h041, 10'h040});
    `CHECK_EQ(wq[1], {2'b10, 16'h5678, 10'h043, 10'h042});
    `CHECK_EQ(banks, 4'h0);
    for (int b = 0; b < 4; b++)
      i_ctrl.issue(1'b1, ACT, 14'h0011, 2'(b));
    i_ctrl.issue(1'b1, PRE, 14'h0000, 2'h2);
    nop(1'b1);
    wait_core;
    `CHECK_EQ(banks, 4'hB);
    i_ctrl.issue(1'b1, PRE, 14'h0400, 2'h1);
    nop(1'b1);
    wait_core;
    `CHECK_EQ(banks, 4'h0);
    ref_cnt = 0;
    i_ctrl.issue(1'b1, REF, 14'h3FFF, 2'h3);
    nop(1'b1);
    repeat (3) @(posedge link_clk);
    `CHECK_EQ(ref_cnt, 1);
    `CHECK_EQ(ref_row, 14'h0000);
    i_ctrl.issue(1'b1, MRS, 14'h0001, 2'h1);
    i_ctrl.issue(1'b0, REF, 14'h0000, 2'h0);
    nop(1'b0);
    wait_core;
    `CHECK_EQ(sref, 1'b1);
    `CHECK_EQ(dll_en, 1'b0);
    `CHECK_EQ(ref_cnt, 1);
    nop(1'b1);
    wait_core;
    `CHECK_EQ(sref, 1'b0);
    `CHECK_EQ(dll_en, 1'b1);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
